// >>> logic/gauge_pmc_pkg.sv
// Constants and types for the gauge power-mode sequencer.
// Assumes a 100 MHz clock and register traffic decoded outside this block.
package gauge_pmc_pkg;

  // Register address window and lockout range
  localparam logic [7:0] LOCK_LO_ADDR      = 8'h20;
  localparam logic [7:0] LOCK_HI_ADDR      = 8'h3F;

  // Power mode request encodings (mode field of the power mode request register)
  localparam logic [1:0] MODE_ACTIVE       = 2'h0;
  localparam logic [1:0] MODE_HIBERNATE    = 2'h1;
  localparam logic [1:0] MODE_SHUTDOWN     = 2'h2;

  // Event mask / clear field position of the config-ready event
  localparam int         CFG_RDY_BIT       = 0;

  // Reset values
  localparam logic       CFG_RDY_RESET     = 1'b0;
  localparam logic       MASK_RESET        = 1'b0;

  // Internal reset and wake sequence lengths
  localparam int         RESET_SEQ_NS      = 1000;
  localparam int         WAKE_SEQ_NS       = 2000;
  localparam int         CLOCK_PERIOD_NS   = 10;
  localparam logic [7:0] RESET_SEQ_CYCLES  = 8'((RESET_SEQ_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [7:0] WAKE_SEQ_CYCLES   = 8'((WAKE_SEQ_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // Power states of the sequencer
  typedef enum logic [2:0] {
    ST_RESETTING = 3'b000,
    ST_SHUTDOWN  = 3'b001,
    ST_WAKING    = 3'b010,
    ST_ACTIVE    = 3'b011,
    ST_HIBERNATE = 3'b100
  } power_state_e;

endpackage : gauge_pmc_pkg

// >>> logic/gauge_power_mode_control.sv
// Power-mode and start-up sequencer of a single-cell fuel gauge.
// Assumes an I2C target front end that decodes register accesses into
// one-cycle strobes on this clock; the wake and supply pins are asynchronous.

`timescale 1ns/10ps

module gauge_power_mode_control
  import gauge_pmc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Asynchronous pins
  input  wire logic       i_supply_valid,
  input  wire logic       i_addr_read_seen,
  // Decoded host register accesses
  input  wire logic       i_reg_write,
  input  wire logic       i_reg_read,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_is_reserved,
  input  wire logic       i_reset_write,
  input  wire logic       i_mode_write,
  input  wire logic [1:0] i_mode_value,
  input  wire logic       i_gauge_start,
  input  wire logic       i_mask_write,
  input  wire logic       i_mask_value,
  input  wire logic       i_clear_write,
  input  wire logic       i_clear_value,
  // Front end events
  input  wire logic       i_limit_fault,
  // Status and control outputs
  output logic            o_config_ready_flag,
  output logic            o_int_n,
  output logic            o_gauging,
  output logic            o_front_end_on,
  output logic            o_cpu_clock_on,
  output logic            o_ack_enable,
  output logic            o_reg_access_ok,
  output logic            o_write_accept,
  output logic            o_regs_clear,
  output logic [2:0]      o_power_state
);

  // State layout notes
  //   supply_meta/supply_sync and wake_meta/wake_sync are the two-flop
  //   synchronisers of the asynchronous pins; nothing but the second
  //   flop of each pair is read by logic.
  //   wake_prev only feeds the rising-edge detect of the wake request;
  //   it resets low, matching the idle level of the pin, so no false
  //   wake follows a reset.
  //   count is shared by the reset and wake sequences, which never overlap.
  //   All outputs are copies held in the same struct, so each output
  //   comes straight from a flip-flop and cannot glitch.

  // All state of the block
  typedef struct packed {
    logic         supply_meta;
    logic         supply_sync;
    logic         wake_meta;
    logic         wake_sync;
    logic         wake_prev;
    power_state_e state;
    logic [7:0]   count;
    logic         cfg_rdy;
    logic         mask;
    logic         gauging;
    logic         int_n;
    logic         front_end_on;
    logic         cpu_clock_on;
    logic         ack_enable;
    logic         access_ok;
    logic         write_accept;
    logic         regs_clear;
  } pmc_state_s;

  pmc_state_s cur;
  pmc_state_s next_cur;

  logic in_lock_range;
  logic wake_edge;

  // Address decode and wake edge from the synchronised pin
  assign in_lock_range = (i_reg_addr >= LOCK_LO_ADDR) && (i_reg_addr <= LOCK_HI_ADDR);
  assign wake_edge     = cur.wake_sync && !cur.wake_prev;

  // Sequencing overview
  //   resetting: register file held at defaults for the reset count,
  //              then flag set and shutdown entered.
  //   shutdown:  only the address watch runs; a synchronised wake edge
  //              with supply present starts the wake count.
  //   waking:    no register access until the wake count expires.
  //   active:    gauging may start; a limit fault while gauging drops to hibernate.
  //   hibernate: registers served and retained, gauging halted.
  // Priority inside one cycle, lowest first: the state branch, mode
  // write, reset write, then supply loss. A flag clear never beats a
  // flag set landing in the same cycle, so a ready event is not lost.
  // Strobes only act when access was open on the previous edge; this
  // keeps a write that races a shutdown from reaching the register file.

  // Next-state logic
  always_comb
  begin
    next_cur             = cur;
    next_cur.supply_meta = i_supply_valid;
    next_cur.supply_sync = cur.supply_meta;
    next_cur.wake_meta   = i_addr_read_seen;
    next_cur.wake_sync   = cur.wake_meta;
    next_cur.wake_prev   = cur.wake_sync;
    next_cur.regs_clear  = 1'b0;
    next_cur.write_accept = 1'b0;

    case (cur.state)
      ST_RESETTING:
      begin
        // Internal reset sequence; defaults restored, then go to shutdown
        next_cur.gauging    = 1'b0;
        next_cur.mask       = MASK_RESET;
        next_cur.regs_clear = 1'b1;
        if (cur.count == 8'h00)
        begin
          next_cur.cfg_rdy = 1'b1;
          next_cur.state   = ST_SHUTDOWN;
        end
        else
        begin
          next_cur.count = cur.count - 8'h01;
        end
      end
      ST_SHUTDOWN:
      begin
        // Only the address watch runs; no ack, contents lost
        next_cur.gauging = 1'b0;
        next_cur.mask    = MASK_RESET;
        if (wake_edge && cur.supply_sync)
        begin
          next_cur.state = ST_WAKING;
          next_cur.count = WAKE_SEQ_CYCLES;
        end
      end
      ST_WAKING:
      begin
        if (cur.count == 8'h00)
        begin
          next_cur.cfg_rdy = 1'b1;
          next_cur.state   = ST_ACTIVE;
        end
        else
        begin
          next_cur.count = cur.count - 8'h01;
        end
      end
      ST_ACTIVE:
      begin
        if (i_gauge_start)
        begin
          next_cur.gauging = 1'b1;
        end
        if (cur.gauging && i_limit_fault)
        begin
          next_cur.gauging = 1'b0;
          next_cur.state   = ST_HIBERNATE;
        end
      end
      ST_HIBERNATE:
      begin
        // Registers stay served and retained; gauging halted
        next_cur.gauging = 1'b0;
      end
      default:
      begin
        next_cur.state = ST_RESETTING;
        next_cur.count = RESET_SEQ_CYCLES;
      end
    endcase

    // Host register traffic in active and hibernate only
    if (cur.access_ok)
    begin
      if (i_reg_write)
      begin
        // Lockout of the configuration window while gauging
        next_cur.write_accept = !(cur.gauging && (in_lock_range || i_reg_is_reserved));
      end
      if (i_mask_write)
      begin
        next_cur.mask = i_mask_value;
      end
      if (i_mode_write && (cur.state == ST_ACTIVE || cur.state == ST_HIBERNATE))
      begin
        case (i_mode_value)
          MODE_ACTIVE:    next_cur.state = ST_ACTIVE;
          MODE_HIBERNATE:
          begin
            next_cur.state   = ST_HIBERNATE;
            next_cur.gauging = 1'b0;
          end
          MODE_SHUTDOWN:
          begin
            next_cur.state   = ST_SHUTDOWN;
            next_cur.gauging = 1'b0;
            next_cur.cfg_rdy = CFG_RDY_RESET;
            next_cur.regs_clear = 1'b1;
          end
          default:        next_cur.state = cur.state;
        endcase
      end
      if (i_reset_write)
      begin
        next_cur.state   = ST_RESETTING;
        next_cur.count   = RESET_SEQ_CYCLES;
        next_cur.gauging = 1'b0;
        next_cur.cfg_rdy = CFG_RDY_RESET;
      end
    end

    // Config-ready flag clear; a set in the same cycle wins
    if (cur.access_ok && i_clear_write && i_clear_value && !(next_cur.cfg_rdy && !cur.cfg_rdy))
    begin
      next_cur.cfg_rdy = 1'b0;
    end

    // Loss of supply forces a reset outside shutdown and the reset sequence
    if (!cur.supply_sync && cur.state != ST_RESETTING && cur.state != ST_SHUTDOWN)
    begin
      next_cur.state = ST_RESETTING;
      next_cur.count = RESET_SEQ_CYCLES;
    end

    // Registered outputs from the next state
    next_cur.int_n        = !(next_cur.cfg_rdy && !next_cur.mask);
    next_cur.front_end_on = (next_cur.state == ST_ACTIVE);
    next_cur.cpu_clock_on = (next_cur.state == ST_ACTIVE) || (next_cur.state == ST_WAKING);
    next_cur.ack_enable   = (next_cur.state == ST_ACTIVE) || (next_cur.state == ST_HIBERNATE);
    next_cur.access_ok    = next_cur.ack_enable;
  end

  // Reset load
  //   Synchronous reset parks the block in the reset sequence with the
  //   interrupt released high and the mask at its default; only
  //   constants are loaded here. The count restarts so a reset pulse
  //   always runs the full sequence before shutdown is entered.

  // State register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      cur       <= '0;
      cur.state <= ST_RESETTING;
      cur.count <= RESET_SEQ_CYCLES;
      cur.int_n <= 1'b1;
      cur.mask  <= MASK_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops
  //   Every output is a plain wire from a struct field, so the
  //   front end sees settled values one cycle after each strobe.
  assign o_config_ready_flag = cur.cfg_rdy;
  assign o_int_n             = cur.int_n;
  assign o_gauging           = cur.gauging;
  assign o_front_end_on      = cur.front_end_on;
  assign o_cpu_clock_on      = cur.cpu_clock_on;
  assign o_ack_enable        = cur.ack_enable;
  assign o_reg_access_ok     = cur.access_ok;
  assign o_write_accept      = cur.write_accept;
  assign o_regs_clear        = cur.regs_clear;
  assign o_power_state       = cur.state;

endmodule : gauge_power_mode_control

// >>> verif/gauge_pmc_props.sv
// Port checker for the power-mode sequencer.
// Sees only top-level ports; bound below.
`timescale 1ns/10ps
module gauge_pmc_props
(
  // Clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  // Host strobes and the front end limit fault
  input wire logic       i_reg_write,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_is_reserved,
  input wire logic       i_gauge_start,
  input wire logic       i_clear_write,
  input wire logic       i_clear_value,
  input wire logic       i_limit_fault,
  // Outputs
  input wire logic       o_config_ready_flag,
  input wire logic       o_gauging,
  input wire logic       o_front_end_on,
  input wire logic       o_cpu_clock_on,
  input wire logic       o_ack_enable,
  input wire logic       o_regs_clear,
  input wire logic       o_reg_access_ok,
  input wire logic       o_write_accept,
  input wire logic [2:0] o_power_state
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Wake steps: enter waking, active with flag once the 200-cycle count runs out
  sequence s_wake; $rose(o_power_state == 3'h2); endsequence
  sequence s_up; ##201 (o_power_state == 3'h3 && o_config_ready_flag); endsequence
  property p_wake; s_wake |-> s_up; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_start; i_gauge_start && o_power_state == 3'h3 && !i_limit_fault |=> o_gauging; endproperty
  a_start: assert property (p_start) else $error("start");
  property p_lock; o_gauging && i_reg_write && (i_reg_is_reserved || i_reg_addr inside {[8'h20:8'h3F]})
    |=> !o_write_accept; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_open; !o_gauging && o_reg_access_ok && i_reg_write && !i_reg_is_reserved |=> o_write_accept; endproperty
  a_open: assert property (p_open) else $error("open");
  property p_shut; o_power_state == 3'h1 |-> !o_reg_access_ok && !o_gauging ##1 !o_write_accept; endproperty
  a_shut: assert property (p_shut) else $error("shut");
  property p_fault; o_gauging && i_limit_fault |=> o_power_state == 3'h4 && !o_gauging; endproperty
  a_fault: assert property (p_fault) else $error("fault");
  property p_clear; o_reg_access_ok && i_clear_write && i_clear_value |=> !o_config_ready_flag; endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_rseq; o_power_state != 3'h0 && $past(o_power_state) == 3'h0
    |-> o_power_state == 3'h1 && o_config_ready_flag; endproperty
  a_rseq: assert property (p_rseq) else $error("rseq");
  // Power domains per mode
  property p_act; o_power_state == 3'h3 |-> o_front_end_on && o_cpu_clock_on && o_ack_enable; endproperty
  a_act: assert property (p_act) else $error("active domains");
  property p_hib; o_power_state == 3'h4 |-> !o_front_end_on && !o_cpu_clock_on && o_ack_enable; endproperty
  a_hib: assert property (p_hib) else $error("hibernate domains");
  // Shutdown entry from a served mode wipes the register file
  property p_wipe; o_power_state == 3'h1 && ($past(o_power_state) == 3'h3 || $past(o_power_state) == 3'h4)
    |-> o_regs_clear; endproperty
  a_wipe: assert property (p_wipe) else $error("shutdown wipe");
endmodule : gauge_pmc_props
bind gauge_power_mode_control gauge_pmc_props i_gauge_pmc_props (.*);

// >>> verif/host_model.sv
// Host model: decoded register strobes and the wake pin.
// Assumes its tasks are called from one process.
`timescale 1ns/10ps
module host_model
(
  // Clock
  input  wire logic i_clock,
  // Host drive
  output logic [7:0] o_strobe,
  output logic [7:0] o_data,
  output logic       o_wake
);
  initial {o_strobe, o_data, o_wake} = '0;
  // One strobe for one cycle, data then released to its inverse
  task automatic hit(input int k, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_data = d;
    o_strobe = 8'h01 << k;
    @(posedge i_clock);
    #1;
    o_strobe = '0;
    o_data = ~d;
  endtask : hit
  // Addressed read in shutdown, no acknowledge awaited
  task automatic wake;
    @(posedge i_clock);
    #1;
    o_wake = 1'b1;
    repeat (4) @(posedge i_clock);
    #1;
    o_wake = 1'b0;
  endtask : wake
endmodule : host_model

// >>> verif/testbench.sv
// Self-checking bench for the power-mode sequencer.
// Assumes supply present throughout and no host reads.
`timescale 1ns/10ps
module testbench;
  logic       clk;
  logic       rst_n;
  logic [7:0] s;
  logic [7:0] d;
  logic       w;
  logic [6:0] v;
  logic [6:0] q[$];
  logic [7:0] lfsr = 8'h3C;
  int         fails;
  int         samples_checked;
  int         cyc;
  event       ev;
  host_model i_host_model (.i_clock(clk), .o_strobe(s), .o_data(d), .o_wake(w));
  gauge_power_mode_control i_gauge_power_mode_control (
    .i_clock(clk), .i_rst_n(rst_n), .i_supply_valid(1'b1), .i_addr_read_seen(w),
    .i_reg_write(s[0] | s[1]), .i_reg_read(1'b0), .i_reg_addr(d), .i_reg_is_reserved(s[1]),
    .i_reset_write(s[6]), .i_mode_write(s[2]), .i_mode_value(d[1:0]), .i_gauge_start(s[3]),
    .i_mask_write(s[4]), .i_mask_value(d[0]), .i_clear_write(s[5]), .i_clear_value(d[0]),
    .i_limit_fault(s[7]), .o_config_ready_flag(v[3]), .o_int_n(v[2]), .o_gauging(v[1]),
    .o_front_end_on(), .o_cpu_clock_on(), .o_ack_enable(), .o_reg_access_ok(),
    .o_write_accept(v[0]), .o_regs_clear(), .o_power_state(v[6:4]));
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      close_out();
    end
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  task automatic idle();
    @(posedge clk);
    #1;
  endtask : idle
  // Note expected state, flag, int_n, gauging, accept
  task automatic ex(input logic [2:0] st, input logic f, input logic n, input logic g, input logic a);
    q.push_back({st, f, n, g, a});
    ->ev;
  endtask : ex
  task automatic till(input logic [2:0] st);
    for (int n = 0; n < 400 && v[6:4] !== st; n++) idle();
  endtask : till
  task automatic cmp(input logic [6:0] e, input logic [6:0] r);
    samples_checked++;
    if (r !== e)
    begin
      fails++;
      $display("CHECK FAILED outputs exp %h seen %h", e, r);
    end
  endtask : cmp
  task automatic close_out();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Monitor takes the oldest note per result
  always @(ev)
    cmp(q.pop_front(), v);
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    till(3'h1); ex(3'h1, 1, 0, 0, 0);
    i_host_model.hit(5, 8'h01); ex(3'h1, 1, 0, 0, 0);
    i_host_model.hit(0, 8'h10); ex(3'h1, 1, 0, 0, 0);
    i_host_model.wake(); till(3'h3); ex(3'h3, 1, 0, 0, 0);
    i_host_model.hit(4, 8'h01); idle(); ex(3'h3, 1, 1, 0, 0);
    i_host_model.hit(4, 8'h00); idle(); ex(3'h3, 1, 0, 0, 0);
    i_host_model.hit(5, 8'h01); idle(); ex(3'h3, 0, 1, 0, 0);
    i_host_model.hit(0, 8'h20); ex(3'h3, 0, 1, 0, 1);
    i_host_model.hit(0, 8'h3F); ex(3'h3, 0, 1, 0, 1);
    i_host_model.hit(3, 8'h00); ex(3'h3, 0, 1, 1, 0);
    for (int i = 0; i < 8; i++)
    begin
      i_host_model.hit(0, i == 0 ? 8'h20 : i == 1 ? 8'h3F : 8'h20 | (rnd() & 8'h1F));
      ex(3'h3, 0, 1, 1, 0);
    end
    i_host_model.hit(1, 8'h00); ex(3'h3, 0, 1, 1, 0);
    i_host_model.hit(0, 8'h40); ex(3'h3, 0, 1, 1, 1);
    i_host_model.hit(7, 8'h00); ex(3'h4, 0, 1, 0, 0);
    i_host_model.hit(0, 8'h25); ex(3'h4, 0, 1, 0, 1);
    for (int m = 0; m < 2; m++)
    begin
      i_host_model.hit(2, 8'(m)); ex(m ? 3'h4 : 3'h3, 0, 1, 0, 0);
    end
    i_host_model.hit(4, 8'h01); idle(); ex(3'h4, 0, 1, 0, 0);
    i_host_model.hit(2, 8'h02); ex(3'h1, 0, 1, 0, 0);
    i_host_model.wake(); till(3'h3); ex(3'h3, 1, 0, 0, 0);
    i_host_model.hit(4, 8'h01); i_host_model.hit(6, 8'h00);
    till(3'h1); ex(3'h1, 1, 0, 0, 0);
    close_out();
  end
endmodule : testbench
